// ==== verilog/srw_supervisor.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srw_defs.svh"

module srw_supervisor #(
   parameter int unsigned HOLD_CYC0 = `SRW_HOLD0_CYC,
   parameter int unsigned HOLD_CYC1 = `SRW_HOLD1_CYC,
   parameter int unsigned HOLD_CYC2 = `SRW_HOLD2_CYC,
   parameter int unsigned HOLD_CYC3 = `SRW_HOLD3_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // comparator results and pins, asynchronous
   input  wire logic        monitor3CmpIn,
   input  wire logic        monitor2CmpIn,
   input  wire logic        supplyAboveTrip,
   input  wire logic        manualResetInput,
   input  wire logic        writeProtectIn,
   input  wire logic        serialDataIn,
   // register port
   input  wire srw_pkg::srw_addr_t regAddr,
   input  wire srw_pkg::srw_data_t regWdata,
   input  wire logic        regWrStb,
   input  wire logic        regRdStb,
   output logic [7:0]       regRdata,
   // write requests from the serial engine, same clock
   input  wire logic        wrReqNv,
   input  wire logic        wrReqVol,
   output logic             wrGrantNv,
   output logic             wrGrantVol,
   output logic             wrRefused,
   // supervisor outputs
   output logic             monitor3FailOut,
   output logic             monitor2FailOut,
   output logic             supplyResetOut,
   output logic             serialDataRx
);
   import srw_pkg::*;

   logic [`SRW_SYNC_W-1:0] syncIn;
   logic [`SRW_SYNC_W-1:0] sync1_reg;
   logic [`SRW_SYNC_W-1:0] sync2_reg;

   logic                   mon3Sync;
   logic                   mon2Sync;
   logic                   supplyOkSync;
   logic                   mrSync;
   logic                   wpSync;
   logic                   sdaSync;

   logic [7:0]             ctrl_reg;
   logic [7:0]             ctrl_next;
   logic [7:0]             statusWord;
   logic                   refused_reg;
   logic                   refused_next;
   logic [7:0]             rdata_next;

   srw_sel_t               holdSel;
   logic [1:0]             protBits;
   logic                   protActive;
   logic                   nvBlocked;
   logic                   volBlocked;
   logic                   nvRefuse;
   logic                   volRefuse;
   logic                   refuseNow;
   logic                   resetCause;
   logic                   ctrlWr;
   logic                   statWr;
   logic                   refusedClr;

   srw_hold_if             holdBus ();

   function automatic logic hitReg(input srw_addr_t a,
                                   input srw_addr_t ofs);
      hitReg = (a == ofs);
   endfunction : hitReg

   // ------------------------------------------------------------------
   // input synchronisers: two flops per lane
   // ------------------------------------------------------------------
   assign syncIn[`SRW_SY_MON3]   = monitor3CmpIn;
   assign syncIn[`SRW_SY_MON2]   = monitor2CmpIn;
   assign syncIn[`SRW_SY_SUPPLY] = supplyAboveTrip;
   assign syncIn[`SRW_SY_MR]     = manualResetInput;
   assign syncIn[`SRW_SY_WP]     = writeProtectIn;
   assign syncIn[`SRW_SY_SDA]    = serialDataIn;

   // lanes reset low, so the supply reads failed until two edges pass
   genvar gi;
   generate
      for (gi = 0; gi < `SRW_SYNC_W; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= syncIn[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate

   assign mon3Sync     = sync2_reg[`SRW_SY_MON3];
   assign mon2Sync     = sync2_reg[`SRW_SY_MON2];
   assign supplyOkSync = sync2_reg[`SRW_SY_SUPPLY];
   assign mrSync       = sync2_reg[`SRW_SY_MR];
   assign wpSync       = sync2_reg[`SRW_SY_WP];
   assign sdaSync      = sync2_reg[`SRW_SY_SDA];

   // ------------------------------------------------------------------
   // voltage monitor fail outputs
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         monitor3FailOut <= 1'b0;
      end else begin
         monitor3FailOut <= mon3Sync;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         monitor2FailOut <= 1'b0;
      end else begin
         monitor2FailOut <= mon2Sync;
      end
   end

   // ------------------------------------------------------------------
   // serial data receiver, never gated
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         serialDataRx <= 1'b0;
      end else begin
         serialDataRx <= sdaSync;
      end
   end

   // ------------------------------------------------------------------
   // supply reset sequencing
   // ------------------------------------------------------------------
   assign holdSel    = srw_sel_t'({ctrl_reg[`SRW_CTRL_SEL_HI],
                                   ctrl_reg[`SRW_CTRL_SEL_LO]});
   assign resetCause = mrSync
                     | !supplyOkSync;

   assign holdBus.cause = resetCause;
   assign holdBus.sel   = holdSel;

   srw_hold_timer #(
      .HOLD_CYC0 (HOLD_CYC0),
      .HOLD_CYC1 (HOLD_CYC1),
      .HOLD_CYC2 (HOLD_CYC2),
      .HOLD_CYC3 (HOLD_CYC3)
   ) u_hold (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .hold     (holdBus.timer)
   );

   // high from reset: power-up is a reset cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         supplyResetOut <= 1'b1;
      end else begin
         supplyResetOut <= resetCause | holdBus.busy;
      end
   end

   // ------------------------------------------------------------------
   // write protection gate
   // ------------------------------------------------------------------
   assign protBits = {ctrl_reg[`SRW_CTRL_BP_HI], ctrl_reg[`SRW_CTRL_BP_LO]};

   // a floating pin is pulled low outside, so only a driven high protects
   assign protActive = wpSync;

   assign nvBlocked  = protActive;
   assign volBlocked = protActive && (protBits != 2'h0);

   // each request kind is judged on its own, both may come at once
   assign nvRefuse  = wrReqNv && nvBlocked;
   assign volRefuse = wrReqVol && volBlocked;
   assign refuseNow = nvRefuse || volRefuse;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrGrantNv <= 1'b0;
      end else begin
         wrGrantNv <= wrReqNv && !nvBlocked;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrGrantVol <= 1'b0;
      end else begin
         wrGrantVol <= wrReqVol && !volBlocked;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wrRefused <= 1'b0;
      end else begin
         wrRefused <= refuseNow;
      end
   end

   // ------------------------------------------------------------------
   // register port
   // ------------------------------------------------------------------
   assign ctrlWr     = regWrStb && hitReg(regAddr, `SRW_CTRL_OFS);
   assign statWr     = regWrStb && hitReg(regAddr, `SRW_STAT_OFS);
   assign refusedClr = statWr && regWdata[`SRW_ST_REFUSED];

   // only the select and protect fields exist, upper bits read zero
   always_comb begin
      ctrl_next = ctrl_reg;
      if (ctrlWr) begin
         ctrl_next                   = `SRW_CTRL_RST;
         ctrl_next[`SRW_CTRL_SEL_LO] = regWdata[`SRW_CTRL_SEL_LO];
         ctrl_next[`SRW_CTRL_SEL_HI] = regWdata[`SRW_CTRL_SEL_HI];
         ctrl_next[`SRW_CTRL_BP_LO]  = regWdata[`SRW_CTRL_BP_LO];
         ctrl_next[`SRW_CTRL_BP_HI]  = regWdata[`SRW_CTRL_BP_HI];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_reg <= `SRW_CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // sticky refusal flag: a new refusal wins over a clear
   always_comb begin
      refused_next = refused_reg;
      if (refusedClr) begin
         refused_next = 1'b0;
      end
      if (refuseNow) begin
         refused_next = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         refused_reg <= 1'b0;
      end else begin
         refused_reg <= refused_next;
      end
   end

   // status bits are assembled apart from the read mux
   always_comb begin
      statusWord                   = 8'h00;
      statusWord[`SRW_ST_MON3]     = monitor3FailOut;
      statusWord[`SRW_ST_MON2]     = monitor2FailOut;
      statusWord[`SRW_ST_RESET]    = supplyResetOut;
      statusWord[`SRW_ST_WP]       = wpSync;
      statusWord[`SRW_ST_MR]       = mrSync;
      statusWord[`SRW_ST_REFUSED]  = refused_reg;
   end

   always_comb begin
      rdata_next = 8'h00;
      if (regRdStb) begin
         if (hitReg(regAddr, `SRW_CTRL_OFS)) begin
            rdata_next = ctrl_reg;
         end else if (hitReg(regAddr, `SRW_STAT_OFS)) begin
            rdata_next = statusWord;
         end
      end
   end

   // read data stands one cycle only, zero otherwise
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdata <= 8'h00;
      end else begin
         regRdata <= rdata_next;
      end
   end

endmodule : srw_supervisor

`default_nettype wire

// ==== verilog/srw_defs.svh ====
`ifndef SRW_DEFS_SVH
`define SRW_DEFS_SVH

// clock rate in cycles per microsecond (10 MHz)
`define SRW_CLK_PER_US   10
`define SRW_US_PER_MS    1000

// selectable reset hold times in milliseconds
`define SRW_HOLD0_MS     50
`define SRW_HOLD1_MS     100
`define SRW_HOLD2_MS     200
`define SRW_HOLD3_MS     300

// hold times as clock cycles
`define SRW_HOLD0_CYC (`SRW_HOLD0_MS * `SRW_US_PER_MS * `SRW_CLK_PER_US)
`define SRW_HOLD1_CYC (`SRW_HOLD1_MS * `SRW_US_PER_MS * `SRW_CLK_PER_US)
`define SRW_HOLD2_CYC (`SRW_HOLD2_MS * `SRW_US_PER_MS * `SRW_CLK_PER_US)
`define SRW_HOLD3_CYC (`SRW_HOLD3_MS * `SRW_US_PER_MS * `SRW_CLK_PER_US)

`define SRW_CNT_W        22
`define SRW_ADDR_W       8
`define SRW_DATA_W       8

// register offsets
`define SRW_CTRL_OFS     8'h00
`define SRW_STAT_OFS     8'h04

// control register fields and reset value
`define SRW_CTRL_SEL_LO  0
`define SRW_CTRL_SEL_HI  1
`define SRW_CTRL_BP_LO   2
`define SRW_CTRL_BP_HI   3
`define SRW_CTRL_RST     8'h00

// status register fields
`define SRW_ST_MON3      0
`define SRW_ST_MON2      1
`define SRW_ST_RESET     2
`define SRW_ST_WP        3
`define SRW_ST_MR        4
`define SRW_ST_REFUSED   5

// synchroniser lanes
`define SRW_SYNC_W       6
`define SRW_SY_MON3      0
`define SRW_SY_MON2      1
`define SRW_SY_SUPPLY    2
`define SRW_SY_MR        3
`define SRW_SY_WP        4
`define SRW_SY_SDA       5

`endif

// ==== verilog/srw_pkg.sv ====
`default_nettype none

package srw_pkg;

   typedef logic [7:0] srw_addr_t;
   typedef logic [7:0] srw_data_t;
   typedef logic [1:0] srw_sel_t;

   typedef enum logic [2:0] {
      ST_RUN    = 3'b001,
      ST_ASSERT = 3'b010,
      ST_HOLD   = 3'b100
   } srw_state_t;

endpackage : srw_pkg

`default_nettype wire

// ==== verilog/srw_hold_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface srw_hold_if;
   import srw_pkg::*;
   logic     cause;
   srw_sel_t sel;
   logic     busy;
   modport timer (input cause, input sel, output busy);
   modport ctrl  (output cause, output sel, input busy);
endinterface : srw_hold_if

`default_nettype wire

// ==== verilog/srw_hold_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srw_defs.svh"

module srw_hold_timer #(
   parameter int unsigned HOLD_CYC0 = `SRW_HOLD0_CYC,
   parameter int unsigned HOLD_CYC1 = `SRW_HOLD1_CYC,
   parameter int unsigned HOLD_CYC2 = `SRW_HOLD2_CYC,
   parameter int unsigned HOLD_CYC3 = `SRW_HOLD3_CYC
) (
   input wire logic core_clk,
   input wire logic rst_b,
   srw_hold_if.timer hold
);
   import srw_pkg::*;

   srw_state_t                state_reg;
   logic [`SRW_CNT_W-1:0]     cnt_reg;
   logic [`SRW_CNT_W-1:0]     limit;

   function automatic logic [`SRW_CNT_W-1:0] holdLimit(input srw_sel_t s);
      unique case (s)
         2'h0: holdLimit = `SRW_CNT_W'(HOLD_CYC0);
         2'h1: holdLimit = `SRW_CNT_W'(HOLD_CYC1);
         2'h2: holdLimit = `SRW_CNT_W'(HOLD_CYC2);
         2'h3: holdLimit = `SRW_CNT_W'(HOLD_CYC3);
      endcase
   endfunction : holdLimit

   assign limit = holdLimit(hold.sel);

   // power-up counts as a reset: hold starts on release
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_HOLD;
      end else begin
         unique case (state_reg)
            ST_RUN: begin
               if (hold.cause) state_reg <= ST_ASSERT;
            end
            ST_ASSERT: begin
               if (!hold.cause) state_reg <= ST_HOLD;
            end
            ST_HOLD: begin
               if (hold.cause) begin
                  state_reg <= ST_ASSERT;
               end else if (cnt_reg >= limit - `SRW_CNT_W'(1)) begin
                  state_reg <= ST_RUN;
               end
            end
            default: state_reg <= ST_HOLD;
         endcase
      end
   end

   // counter restarts whenever a cause appears
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= '0;
      end else if (state_reg == ST_HOLD && !hold.cause) begin
         cnt_reg <= cnt_reg + `SRW_CNT_W'(1);
      end else begin
         cnt_reg <= '0;
      end
   end

   assign hold.busy = (state_reg != ST_RUN);

endmodule : srw_hold_timer

`default_nettype wire

// ==== tb/srw_supervisor_checker.sv ====
`timescale 1ns/100ps
`default_nettype none

module srw_supervisor_checker #(
   parameter int unsigned HOLD_CYC0 = 20,
   parameter int unsigned HOLD_CYC1 = 40,
   parameter int unsigned HOLD_CYC2 = 60,
   parameter int unsigned HOLD_CYC3 = 80
) (
   input wire logic               core_clk,
   input wire logic               rst_b,
   input wire logic               monitor3CmpIn,
   input wire logic               monitor2CmpIn,
   input wire logic               supplyAboveTrip,
   input wire logic               manualResetInput,
   input wire logic               writeProtectIn,
   input wire logic               serialDataIn,
   input wire srw_pkg::srw_addr_t regAddr,
   input wire srw_pkg::srw_data_t regWdata,
   input wire logic               regWrStb,
   input wire logic               wrReqNv,
   input wire logic               wrReqVol,
   input wire logic               wrGrantNv,
   input wire logic               wrGrantVol,
   input wire logic               wrRefused,
   input wire logic               monitor3FailOut,
   input wire logic               monitor2FailOut,
   input wire logic               supplyResetOut,
   input wire logic               serialDataRx
);
   import srw_pkg::*;
   logic [3:0]  ctrlReg;
   int unsigned idleReg;
   int unsigned lim;
   int unsigned holdLim;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         ctrlReg <= 4'h0;
      else if (regWrStb && regAddr == 8'h00)
         ctrlReg <= regWdata[3:0];
   end
   // cycles since any reset cause was last seen
   // limit of the hold now running is taken while a cause stands
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         idleReg <= 0;
         holdLim <= HOLD_CYC0;
      end else if (manualResetInput || !supplyAboveTrip) begin
         idleReg <= 0;
         holdLim <= lim;
      end else begin
         idleReg <= idleReg + 1;
      end
   end
   always_comb begin
      case (ctrlReg[1:0])
         2'h0: lim = HOLD_CYC0;
         2'h1: lim = HOLD_CYC1;
         2'h2: lim = HOLD_CYC2;
         default: lim = HOLD_CYC3;
      endcase
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_mon3_high: assert property (
      monitor3CmpIn [*5] |-> monitor3FailOut) else $error("mon3 low");
   a_mon3_low: assert property (
      !monitor3CmpIn [*5] |-> !monitor3FailOut) else $error("mon3 high");
   a_mon2_track: assert property (
      $stable(monitor2CmpIn) [*4] |-> monitor2FailOut == monitor2CmpIn)
      else $error("mon2 lags");
   a_mr_start: assert property (
      $rose(manualResetInput) |-> ##[1:4] supplyResetOut)
      else $error("no reset");
   a_hold_kept: assert property (
      idleReg >= 4 && idleReg < holdLim |-> supplyResetOut)
      else $error("reset short");
   a_hold_ends: assert property (
      idleReg > holdLim + 8 |-> !supplyResetOut) else $error("reset long");
   a_nv_refuse: assert property (
      writeProtectIn [*4] ##0 wrReqNv |=> wrRefused && !wrGrantNv)
      else $error("nv let through");
   a_nv_grant: assert property (
      !writeProtectIn [*4] ##0 wrReqNv |=> wrGrantNv)
      else $error("nv refused");
   a_vol_lock: assert property (
      writeProtectIn [*4] ##0 (wrReqVol && ctrlReg[3:2] != 2'b00)
      |=> wrRefused && !wrGrantVol) else $error("vol let through");
   a_vol_open: assert property (
      (!writeProtectIn || ctrlReg[3:2] == 2'b00) [*4] ##0 wrReqVol
      |=> wrGrantVol) else $error("vol refused");
   a_sda_track: assert property (
      $stable(serialDataIn) [*4] |-> serialDataRx == serialDataIn)
      else $error("sda gated");
endmodule : srw_supervisor_checker

bind srw_supervisor srw_supervisor_checker #(
   .HOLD_CYC0(HOLD_CYC0), .HOLD_CYC1(HOLD_CYC1),
   .HOLD_CYC2(HOLD_CYC2), .HOLD_CYC3(HOLD_CYC3)
) u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .monitor3CmpIn(monitor3CmpIn),
   .monitor2CmpIn(monitor2CmpIn), .supplyAboveTrip(supplyAboveTrip),
   .manualResetInput(manualResetInput), .writeProtectIn(writeProtectIn),
   .serialDataIn(serialDataIn), .regAddr(regAddr), .regWdata(regWdata),
   .regWrStb(regWrStb), .wrReqNv(wrReqNv), .wrReqVol(wrReqVol),
   .wrGrantNv(wrGrantNv), .wrGrantVol(wrGrantVol), .wrRefused(wrRefused),
   .monitor3FailOut(monitor3FailOut), .monitor2FailOut(monitor2FailOut),
   .supplyResetOut(supplyResetOut), .serialDataRx(serialDataRx)
);

`default_nettype wire

// ==== tb/srw_board_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module srw_board_model (
   input  wire logic core_clk,
   input  wire logic supplyResetOut,
   output var logic  manualResetInput,
   output var int    relCnt
);
   initial begin
      manualResetInput = 1'b0;
      relCnt = 0;
   end
   // push button held for n cycles
   task automatic press(input int n);
      manualResetInput <= 1'b1;
      repeat (n) @(posedge core_clk);
      manualResetInput <= 1'b0;
   endtask : press
   // cycles reset stays up after the button is let go
   always @(posedge core_clk) begin
      if (manualResetInput)
         relCnt <= 0;
      else if (supplyResetOut)
         relCnt <= relCnt + 1;
   end
endmodule : srw_board_model

`default_nettype wire

// ==== tb/srw_supervisor_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module srw_supervisor_tb;
   import srw_pkg::*;
   localparam int HC[4] = '{20, 40, 60, 80};
   logic      core_clk, rst_b, mon3, mon2, supOk, wpOn, sdaIn, mrIn;
   logic      wrStb, rdStb, reqNv, reqVol, gNv, gVol, refused;
   logic      fail3, fail2, rstOut, sdaRx;
   logic[7:0] rdata;
   srw_addr_t addr;
   srw_data_t wdata;
   tri0       wpPin;
   int        relCnt, nErrors, checks;

   // board pull-down leaves the pin low when not driven
   assign wpPin = wpOn ? 1'b1 : 1'bz;

   srw_supervisor #(.HOLD_CYC0(HC[0]), .HOLD_CYC1(HC[1]),
      .HOLD_CYC2(HC[2]), .HOLD_CYC3(HC[3])) DUT (
      .core_clk(core_clk), .rst_b(rst_b), .monitor3CmpIn(mon3),
      .monitor2CmpIn(mon2), .supplyAboveTrip(supOk),
      .manualResetInput(mrIn), .writeProtectIn(wpPin),
      .serialDataIn(sdaIn), .regAddr(addr), .regWdata(wdata),
      .regWrStb(wrStb), .regRdStb(rdStb), .regRdata(rdata),
      .wrReqNv(reqNv), .wrReqVol(reqVol), .wrGrantNv(gNv),
      .wrGrantVol(gVol), .wrRefused(refused), .monitor3FailOut(fail3),
      .monitor2FailOut(fail2), .supplyResetOut(rstOut),
      .serialDataRx(sdaRx));
   srw_board_model bd (.core_clk(core_clk), .supplyResetOut(rstOut),
      .manualResetInput(mrIn), .relCnt(relCnt));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         nErrors++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input srw_addr_t a, input srw_data_t d);
      addr <= a;
      wdata <= d;
      wrStb <= 1'b1;
      @(posedge core_clk);
      wrStb <= 1'b0;
      @(posedge core_clk);
   endtask : wr

   task automatic rd(input srw_addr_t a, output logic [7:0] d);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge core_clk);
      rdStb <= 1'b0;
      @(negedge core_clk);
      d = rdata;
      @(posedge core_clk);
   endtask : rd

   task automatic waitRel;
      int n = 0;
      while (rstOut !== 1'b0 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      chk(rstOut, 1'b0);
      @(posedge core_clk);
   endtask : waitRel

   task automatic t_powerup;
      mon3 <= 1'b1;
      mon2 <= 1'b1;
      sdaIn <= 1'b1;
      repeat (HC[0] - 1) @(posedge core_clk);
      @(negedge core_clk);
      chk(rstOut, 1'b1);
      chk({fail3, fail2, sdaRx}, 3'b111);
      waitRel;
      mon3 <= 1'b0;
      mon2 <= 1'b0;
      sdaIn <= 1'b0;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      chk({fail3, fail2, sdaRx}, 3'b000);
      @(posedge core_clk);
      $display("t_powerup done");
   endtask : t_powerup

   task automatic t_holdsel;
      logic [7:0] d;
      rd(8'h10, d);
      chk(d, 8'h00);
      for (int s = 0; s < 4; s++) begin
         wr(8'h00, 8'(s));
         rd(8'h00, d);
         chk(d, 8'(s));
         bd.press(3);
         @(negedge core_clk);
         chk(rstOut, 1'b1);
         waitRel;
         chk(relCnt >= HC[s] && relCnt <= HC[s] + 8, 1'b1);
      end
      $display("t_holdsel done");
   endtask : t_holdsel

   task automatic t_restart;
      wr(8'h00, 8'h00);
      bd.press(3);
      repeat (HC[0] / 2) @(posedge core_clk);
      bd.press(3);
      waitRel;
      chk(relCnt >= HC[0] && relCnt <= HC[0] + 8, 1'b1);
      supOk <= 1'b0;
      repeat (2) @(posedge core_clk);
      supOk <= 1'b1;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk(rstOut, 1'b1);
      waitRel;
      $display("t_restart done");
   endtask : t_restart

   task automatic t_wp;
      logic [7:0] d;
      for (int w = 0; w < 2; w++)
         for (int b = 0; b < 4; b++) begin
            wpOn <= w[0];
            wr(8'h00, 8'(b << 2));
            repeat (3) @(posedge core_clk);
            reqNv <= 1'b1;
            reqVol <= 1'b1;
            @(posedge core_clk);
            reqNv <= 1'b0;
            reqVol <= 1'b0;
            @(negedge core_clk);
            chk({gNv, gVol, refused}, {~w[0], ~(w[0] && b != 0), w[0]});
            @(posedge core_clk);
            rd(8'h04, d);
            chk(d[5:0], {w[0], 1'b0, w[0], 3'b000});
            wr(8'h04, 8'h20);
         end
      $display("t_wp done");
   endtask : t_wp

   task automatic test_done;
      $display("checks=%0d errors=%0d", checks, nErrors);
      if (nErrors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   initial begin
      {rst_b, mon3, mon2, wpOn, sdaIn, wrStb, rdStb, reqNv, reqVol} = '0;
      {supOk, addr, wdata, nErrors, checks} = '0;
      supOk = 1'b1;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      t_powerup;
      t_holdsel;
      t_restart;
      t_wp;
      test_done;
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      nErrors++;
      test_done;
   end
endmodule : srw_supervisor_tb

`default_nettype wire
